/* src/iefc_decode.sv */
`timescale 1ns/10ps
module iefc_decode (
    // Received field
    input  wire logic [3:0]  field,
    input  wire logic [15:0] raw,
    // Meaning
    output logic      [25:0] value,
    output logic             invalid
);
    always_comb begin
        value   = 26'h0;
        invalid = 1'b0;
        unique case (field)
            iefc_pkg::F_KEY: begin
                invalid = iefc_pkg::key_reserved(raw[3:0]);
                value   = invalid ? 26'h0 : {22'h0, raw[3:0]};
            end
            iefc_pkg::F_MTU: begin
                value   = {14'h0, iefc_pkg::mtu_octets(raw[2:0])};
                invalid = (value == 26'h0);
            end
            iefc_pkg::F_THR: begin
                if (raw[4:0] == iefc_pkg::THR_BEST) begin
                    value = iefc_pkg::DEC_BEST;
                end else if (raw[4:0] != iefc_pkg::THR_NONE) begin
                    value   = iefc_pkg::thr_octets(raw[4:0]);
                    invalid = (value == 26'h0);
                end
            end
            // Strings are 7-bit ASCII, one octet each
            iefc_pkg::F_CHR: begin
                invalid = raw[7];
                value   = invalid ? 26'h0 : {18'h0, raw[7:0]};
            end
            iefc_pkg::F_LOC, iefc_pkg::F_LEN, iefc_pkg::F_MAXD,
            iefc_pkg::F_CC, iefc_pkg::F_ACT, iefc_pkg::F_IDX,
            iefc_pkg::F_REF: begin
                value = {10'h0, raw};
            end
            default: invalid = 1'b1;
        endcase
    end
endmodule

/* src/iefc_host.sv */
`timescale 1ns/10ps
module iefc_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Encode orders
    input  wire logic        enc_valid,
    input  wire logic [3:0]  enc_field,
    input  wire logic [31:0] enc_value,
    input  wire logic        ctx_timer_run,
    output logic             enc_ready,
    output logic             enc_err,
    // Serial pins towards the mobile termination
    output logic             tx_bit,
    output logic             tx_strobe,
    input  wire logic        rx_bit,
    input  wire logic        rx_strobe,
    // Decode results
    input  wire logic [3:0]  rx_field,
    output logic             dec_valid,
    output logic [3:0]       dec_field,
    output logic [15:0]      dec_raw,
    output logic [25:0]      dec_value,
    output logic             dec_invalid
);
    typedef enum logic [1:0] {
        ENC_IDLE = 2'b00,
        ENC_LOW  = 2'b01,
        ENC_HIGH = 2'b10
    } iefc_enc_t;

    iefc_enc_t   st_r, st_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic        tx_bit_r, tx_bit_nxt, tx_stb_r, tx_stb_nxt;
    logic        rdy_r, rdy_nxt, err_r, err_nxt;
    logic [15:0] code;
    logic [4:0]  w;
    logic        bad;

    // Meaning to code, with range and reserved checks
    always_comb begin
        w    = iefc_pkg::field_width(enc_field);
        code = 16'(enc_value);
        bad  = (w == 5'h00) || ((enc_value >> w) != 32'h0);
        unique case (enc_field)
            iefc_pkg::F_KEY:
                bad = bad || iefc_pkg::key_reserved(enc_value[3:0]);
            iefc_pkg::F_MTU: begin
                code = {13'h0, iefc_pkg::mtu_code(enc_value)};
                bad  = (code == 16'h0);
            end
            iefc_pkg::F_THR: begin
                if (enc_value == iefc_pkg::ENC_BEST) begin
                    code = {11'h0, iefc_pkg::THR_BEST};
                end else begin
                    code = {11'h0, iefc_pkg::thr_code(enc_value)};
                end
                bad = (enc_value != 32'h0) && (code == 16'h0);
            end
            iefc_pkg::F_ACT:
                bad = bad || !ctx_timer_run;
            default: ;
        endcase
    end

    // Serialiser: bit stands two cycles, strobe high in the second
    always_comb begin
        st_nxt     = st_r;
        sh_nxt     = sh_r;
        cnt_nxt    = cnt_r;
        tx_bit_nxt = tx_bit_r;
        tx_stb_nxt = 1'b0;
        rdy_nxt    = rdy_r;
        err_nxt    = 1'b0;
        unique case (st_r)
            ENC_IDLE: begin
                if (enc_valid) begin
                    if (bad) begin
                        err_nxt = 1'b1;
                    end else begin
                        sh_nxt     = 16'(code << (5'd16 - w));
                        cnt_nxt    = w;
                        tx_bit_nxt = sh_nxt[15];
                        rdy_nxt    = 1'b0;
                        st_nxt     = ENC_LOW;
                    end
                end
            end
            ENC_LOW: begin
                tx_stb_nxt = 1'b1;
                st_nxt     = ENC_HIGH;
            end
            ENC_HIGH: begin
                if (cnt_r == 5'h01) begin
                    rdy_nxt = 1'b1;
                    st_nxt  = ENC_IDLE;
                end else begin
                    sh_nxt     = {sh_r[14:0], 1'b0};
                    cnt_nxt    = cnt_r - 5'h01;
                    tx_bit_nxt = sh_r[14];
                    st_nxt     = ENC_LOW;
                end
            end
            default: st_nxt = ENC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r     <= ENC_IDLE;
            sh_r     <= 16'h0000;
            cnt_r    <= 5'h00;
            tx_bit_r <= 1'b0;
            tx_stb_r <= 1'b0;
            rdy_r    <= 1'b1;
            err_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            sh_r     <= sh_nxt;
            cnt_r    <= cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_stb_r <= tx_stb_nxt;
            rdy_r    <= rdy_nxt;
            err_r    <= err_nxt;
        end
    end

    assign enc_ready = rdy_r;
    assign enc_err   = err_r;
    assign tx_bit    = tx_bit_r;
    assign tx_strobe = tx_stb_r;

    // Receive side; pins pass two flops first
    logic [1:0]  bit_s_r, bit_s_nxt;
    logic [2:0]  stb_s_r, stb_s_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic [4:0]  rcnt_r, rcnt_nxt;
    logic [3:0]  rfld_r, rfld_nxt;
    logic        pend_r, pend_nxt;
    logic [15:0] raw_q_r, raw_q_nxt;
    logic [3:0]  fld_q_r, fld_q_nxt;
    logic        dv_r, dv_nxt, di_r, di_nxt;
    logic [3:0]  df_r, df_nxt;
    logic [15:0] dr_r, dr_nxt;
    logic [25:0] dval_r, dval_nxt;
    logic [25:0] m_value;
    logic        m_invalid;
    logic [3:0]  f_use;

    iefc_decode iefc_decode_i (
        .field   (fld_q_r),
        .raw     (raw_q_r),
        .value   (m_value),
        .invalid (m_invalid)
    );

    // Field chosen at the first bit so a late change cannot split it
    always_comb begin
        bit_s_nxt = {bit_s_r[0], rx_bit};
        stb_s_nxt = {stb_s_r[1:0], rx_strobe};
        acc_nxt   = acc_r;
        rcnt_nxt  = rcnt_r;
        rfld_nxt  = rfld_r;
        pend_nxt  = 1'b0;
        raw_q_nxt = raw_q_r;
        fld_q_nxt = fld_q_r;
        f_use     = (rcnt_r == 5'h00) ? rx_field : rfld_r;
        if (stb_s_r[1] && !stb_s_r[2]) begin
            // Fresh start per field so no stale bits reach the raw word
            acc_nxt  = (rcnt_r == 5'h00) ? {15'h0000, bit_s_r[1]}
                                         : {acc_r[14:0], bit_s_r[1]};
            rfld_nxt = f_use;
            if (rcnt_r + 5'h01 >= iefc_pkg::field_width(f_use)) begin
                pend_nxt  = 1'b1;
                raw_q_nxt = acc_nxt;
                fld_q_nxt = f_use;
                rcnt_nxt  = 5'h00;
            end else begin
                rcnt_nxt = rcnt_r + 5'h01;
            end
        end
        dv_nxt   = pend_r;
        di_nxt   = pend_r ? m_invalid : di_r;
        dval_nxt = pend_r ? m_value : dval_r;
        df_nxt   = pend_r ? fld_q_r : df_r;
        dr_nxt   = pend_r ? raw_q_r : dr_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_s_r <= 2'b00;
            stb_s_r <= 3'b000;
            acc_r   <= 16'h0000;
            rcnt_r  <= 5'h00;
            rfld_r  <= 4'h0;
            pend_r  <= 1'b0;
            raw_q_r <= 16'h0000;
            fld_q_r <= 4'h0;
            dv_r    <= 1'b0;
            di_r    <= 1'b0;
            df_r    <= 4'h0;
            dr_r    <= 16'h0000;
            dval_r  <= 26'h0;
        end else begin
            bit_s_r <= bit_s_nxt;
            stb_s_r <= stb_s_nxt;
            acc_r   <= acc_nxt;
            rcnt_r  <= rcnt_nxt;
            rfld_r  <= rfld_nxt;
            pend_r  <= pend_nxt;
            raw_q_r <= raw_q_nxt;
            fld_q_r <= fld_q_nxt;
            dv_r    <= dv_nxt;
            di_r    <= di_nxt;
            df_r    <= df_nxt;
            dr_r    <= dr_nxt;
            dval_r  <= dval_nxt;
        end
    end

    assign dec_valid   = dv_r;
    assign dec_invalid = di_r;
    assign dec_field   = df_r;
    assign dec_raw     = dr_r;
    assign dec_value   = dval_r;

    logic take;
    assign take = enc_valid && rdy_r && (st_r == ENC_IDLE);

    property p_key_rsv;
        @(posedge clk) disable iff (!rst_n)
        take && enc_field == iefc_pkg::F_KEY && enc_value[3:0] >= 4'h4 &&
        enc_value[3:0] <= 4'hE |=> enc_err && enc_ready;
    endproperty
    a_key_rsv: assert property (p_key_rsv) else $error("key mask accepted");

    property p_loc_range;
        @(posedge clk) disable iff (!rst_n)
        take && enc_field == iefc_pkg::F_LOC && enc_value[31:14] != 18'h0
        |=> enc_err && !tx_strobe;
    endproperty
    a_loc_range: assert property (p_loc_range) else $error("loc too wide");

    property p_len_frame;
        @(posedge clk) disable iff (!rst_n)
        take && enc_field == iefc_pkg::F_LEN && enc_value < 32'd2048
        |=> !enc_ready ##1 tx_strobe ##1 !tx_strobe ##20 enc_ready;
    endproperty
    a_len_frame: assert property (p_len_frame) else $error("len frame");

    property p_mtu_dec;
        @(posedge clk) disable iff (!rst_n)
        dec_valid && dec_field == iefc_pkg::F_MTU && dec_raw[2:0] == 3'h4
        |-> dec_value == 26'd1500 && !dec_invalid;
    endproperty
    a_mtu_dec: assert property (p_mtu_dec) else $error("mtu 1500");

    property p_mtu_rsv;
        @(posedge clk) disable iff (!rst_n)
        dec_valid && dec_field == iefc_pkg::F_MTU &&
        (dec_raw[2:0] == 3'h0 || dec_raw[2:0] >= 3'h6) |-> dec_invalid;
    endproperty
    a_mtu_rsv: assert property (p_mtu_rsv) else $error("mtu reserved");

    property p_cc_range;
        @(posedge clk) disable iff (!rst_n)
        take && enc_field == iefc_pkg::F_CC && enc_value[31:10] == 22'h0
        |=> !enc_err && !enc_ready;
    endproperty
    a_cc_range: assert property (p_cc_range) else $error("cc refused");

    property p_thr_rsv;
        @(posedge clk) disable iff (!rst_n)
        dec_valid && dec_field == iefc_pkg::F_THR &&
        dec_raw[4:0] >= 5'd19 && dec_raw[4:0] <= 5'd30
        |-> dec_invalid && dec_value == 26'h0;
    endproperty
    a_thr_rsv: assert property (p_thr_rsv) else $error("thr reserved");

    property p_thr_top;
        @(posedge clk) disable iff (!rst_n)
        dec_valid && dec_field == iefc_pkg::F_THR && dec_raw[4:0] == 5'd18
        |-> dec_value == 26'd50000000;
    endproperty
    a_thr_top: assert property (p_thr_top) else $error("thr 18");

    property p_act_timer;
        @(posedge clk) disable iff (!rst_n)
        take && enc_field == iefc_pkg::F_ACT && !ctx_timer_run |=> enc_err;
    endproperty
    a_act_timer: assert property (p_act_timer) else $error("act no timer");

    property p_ref_range;
        @(posedge clk) disable iff (!rst_n)
        take && enc_field == iefc_pkg::F_REF && enc_value > 32'd255
        |=> enc_err;
    endproperty
    a_ref_range: assert property (p_ref_range) else $error("ref range");

    property p_idx_pass;
        @(posedge clk) disable iff (!rst_n)
        dec_valid && dec_field == iefc_pkg::F_IDX
        |-> dec_value == {10'h0, dec_raw} && !dec_invalid;
    endproperty
    a_idx_pass: assert property (p_idx_pass) else $error("idx decode");

    c_enc_err: cover property (@(posedge clk) disable iff (!rst_n) enc_err);
    c_dec_thr: cover property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec_field == iefc_pkg::F_THR);
    c_enc_done: cover property (@(posedge clk) disable iff (!rst_n)
        !enc_ready ##1 enc_ready);
endmodule

/* src/iefc_pkg.sv */
// Operation
// - Key mask is 4 bits: 0001 type, 0010 status, 0011 both, 1111 all, 0100-1110 reserved
// - Location area field is 14 bits, any value, serving or neighbour cell
// - Length indicator is 11-bit unsigned bit count of next element, 0 to 2047
// - Transmission unit code 3 bits: 296, 576, 1006, 1500, 2002; 0, 6, 7 reserved
// - Country code field is 10 bits, any value
// - Mean throughput 5 bits: 0 no value, 31 best effort, 19-30 reserved
// - Mean throughput codes 1-18 decode to 1-2-5 steps from 100 to 50000000 octets/h
// - Mean active throughput uses peak table; valid only while activity timer runs; only the encoder checks the timer, decode ignores it
// - Message index is 16-bit unsigned pointer into the short message stack
// - Message reference is 8-bit unsigned, 0 to 255
package iefc_pkg;
    localparam int W_KEY   = 4;
    localparam int W_LOC   = 14;
    localparam int W_LEN   = 11;
    localparam int W_MAXD  = 8;
    localparam int W_MTU   = 3;
    localparam int W_CC    = 10;
    localparam int W_THR   = 5;
    localparam int W_ACT   = 4;
    localparam int W_IDX   = 16;
    localparam int W_REF   = 8;
    localparam int W_CHR   = 8;
    localparam int RAW_W   = 16;
    localparam int VAL_W   = 26;
    localparam int CNT_W   = 5;
    localparam int THR_BASE    = 100;
    localparam int THR_LAST    = 18;
    localparam logic [4:0]  THR_NONE = 5'h00;
    localparam logic [4:0]  THR_BEST = 5'h1F;
    localparam logic [31:0] ENC_BEST = 32'hFFFF_FFFF;
    localparam logic [25:0] DEC_BEST = 26'h3FF_FFFF;
    localparam logic [3:0]  KEY_TYPE = 4'h1;
    localparam logic [3:0]  KEY_STAT = 4'h2;
    localparam logic [3:0]  KEY_BOTH = 4'h3;
    localparam logic [3:0]  KEY_ALL  = 4'hF;

    typedef enum logic [3:0] {
        F_KEY  = 4'b0000,
        F_LOC  = 4'b0001,
        F_LEN  = 4'b0010,
        F_MAXD = 4'b0011,
        F_MTU  = 4'b0100,
        F_CC   = 4'b0101,
        F_THR  = 4'b0110,
        F_ACT  = 4'b0111,
        F_IDX  = 4'b1000,
        F_REF  = 4'b1001,
        F_CHR  = 4'b1010
    } iefc_field_t;

    function automatic logic [4:0] field_width(input logic [3:0] f);
        case (f)
            F_KEY:   field_width = 5'(W_KEY);
            F_LOC:   field_width = 5'(W_LOC);
            F_LEN:   field_width = 5'(W_LEN);
            F_MAXD:  field_width = 5'(W_MAXD);
            F_MTU:   field_width = 5'(W_MTU);
            F_CC:    field_width = 5'(W_CC);
            F_THR:   field_width = 5'(W_THR);
            F_ACT:   field_width = 5'(W_ACT);
            F_IDX:   field_width = 5'(W_IDX);
            F_REF:   field_width = 5'(W_REF);
            F_CHR:   field_width = 5'(W_CHR);
            default: field_width = 5'h00;
        endcase
    endfunction

    function automatic logic key_reserved(input logic [3:0] k);
        key_reserved = !(k == KEY_TYPE || k == KEY_STAT ||
                         k == KEY_BOTH || k == KEY_ALL);
    endfunction

    // Zero marks a reserved code
    function automatic logic [11:0] mtu_octets(input logic [2:0] c);
        case (c)
            3'h1:    mtu_octets = 12'd296;
            3'h2:    mtu_octets = 12'd576;
            3'h3:    mtu_octets = 12'd1006;
            3'h4:    mtu_octets = 12'd1500;
            3'h5:    mtu_octets = 12'd2002;
            default: mtu_octets = 12'h000;
        endcase
    endfunction

    function automatic logic [2:0] mtu_code(input logic [31:0] o);
        mtu_code = 3'h0;
        for (int c = 1; c < 6; c++) begin
            if (o == {20'h0_0000, mtu_octets(3'(c))}) mtu_code = 3'(c);
        end
    endfunction

    // 1-2-5 ladder; zero outside codes 1..18
    function automatic logic [25:0] thr_octets(input logic [4:0] c);
        int v;
        v = THR_BASE;
        for (int i = 1; i < THR_LAST; i++) begin
            if (i < int'(c)) begin
                if (i % 3 == 2) v = v * 5 / 2;
                else v = v * 2;
            end
        end
        thr_octets = (c >= 5'h01 && int'(c) <= THR_LAST) ? 26'(v) : 26'h0;
    endfunction

    function automatic logic [4:0] thr_code(input logic [31:0] o);
        thr_code = 5'h00;
        for (int c = 1; c <= THR_LAST; c++) begin
            if (o == {6'h00, thr_octets(5'(c))}) thr_code = 5'(c);
        end
    endfunction
endpackage

/* testbench/iefc_dev_model.sv */
`timescale 1ns/10ps
module iefc_dev_model (
    // Clock
    input  wire logic clk,
    // Pins from the host
    input  wire logic tx_bit,
    input  wire logic tx_strobe,
    // Pins towards the host
    output logic      rx_bit,
    output logic      rx_strobe
);
    logic [31:0] got_bits;
    int          got_n;

    initial begin
        rx_bit    = 1'b0;
        rx_strobe = 1'b0;
        got_bits  = 32'h0000_0000;
        got_n     = 0;
    end

    // Fields arrive MSB first, one bit per strobe
    always @(posedge clk) begin
        if (tx_strobe === 1'b1) begin
            got_bits <= {got_bits[30:0], tx_bit};
            got_n    <= got_n + 1;
        end
    end

    task automatic clear();
        got_bits = 32'h0000_0000;
        got_n    = 0;
    endtask

    // Strobe held 3 cycles each way, host needs 2
    task automatic send(input logic [15:0] raw, input int w);
        for (int i = w - 1; i >= 0; i--) begin
            rx_bit = raw[i];
            repeat (3) @(posedge clk);
            #1 rx_strobe = 1'b1;
            repeat (3) @(posedge clk);
            #1 rx_strobe = 1'b0;
        end
        // Released line shows no stale value
        rx_bit = ~rx_bit;
    endtask
endmodule

/* testbench/iefc_host_tb.sv */
`timescale 1ns/10ps
module iefc_host_tb;
    logic        clk;
    logic        rst_n;
    logic        enc_valid;
    logic [3:0]  enc_field;
    logic [31:0] enc_value;
    logic        ctx_timer_run;
    logic        enc_ready;
    logic        enc_err;
    logic        tx_bit;
    logic        tx_strobe;
    logic        rx_bit;
    logic        rx_strobe;
    logic [3:0]  rx_field;
    logic        dec_valid;
    logic [3:0]  dec_field;
    logic [15:0] dec_raw;
    logic [25:0] dec_value;
    logic        dec_invalid;
    int          n_errors;
    int          cmp_count;
    int          cyc;
    int          n_dec;

    iefc_host iefc_host_i (
        .clk(clk), .rst_n(rst_n), .enc_valid(enc_valid),
        .enc_field(enc_field), .enc_value(enc_value),
        .ctx_timer_run(ctx_timer_run), .enc_ready(enc_ready),
        .enc_err(enc_err), .tx_bit(tx_bit), .tx_strobe(tx_strobe),
        .rx_bit(rx_bit), .rx_strobe(rx_strobe), .rx_field(rx_field),
        .dec_valid(dec_valid), .dec_field(dec_field), .dec_raw(dec_raw),
        .dec_value(dec_value), .dec_invalid(dec_invalid)
    );

    iefc_dev_model iefc_dev_model_i (
        .clk(clk), .tx_bit(tx_bit), .tx_strobe(tx_strobe),
        .rx_bit(rx_bit), .rx_strobe(rx_strobe)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Run takes some 2850 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (dec_valid === 1'b1) n_dec <= n_dec + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Ladder from leading digit and decade, not from the step rule
    function automatic logic [31:0] thr_exp(input int c);
        logic [31:0] v;
        v = ((c - 1) % 3 == 0) ? 32'h0000_0064
            : ((c - 1) % 3 == 1) ? 32'h0000_00C8 : 32'h0000_01F4;
        for (int i = 0; i < (c - 1) / 3; i++) begin
            v = v * 10;
        end
        return v;
    endfunction

    task automatic enc(input logic [3:0] f, input logic [31:0] v, input int w,
                       input logic refuse, input logic [15:0] code);
        int n;
        iefc_dev_model_i.clear();
        enc_field = f;
        enc_value = v;
        enc_valid = 1'b1;
        @(posedge clk);
        #1 enc_valid = 1'b0;
        if (refuse) begin
            check(enc_err === 1'b1 && enc_ready === 1'b1, "no refusal");
            @(posedge clk);
            #1 check(enc_err === 1'b0, "refusal pulse too long");
            check(iefc_dev_model_i.got_n == 0, "refused field sent");
            return;
        end
        check(enc_ready === 1'b0 && enc_err === 1'b0, "not taken");
        n = 0;
        while (enc_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        check(n == 2 * w, "transfer length");
        check(iefc_dev_model_i.got_n == w, "bit count");
        check(iefc_dev_model_i.got_bits[15:0] === code, "bit pattern");
    endtask

    task automatic dec(input logic [3:0] f, input logic [15:0] raw, input int w,
                       input logic [25:0] val, input logic bad);
        n_dec = 0;
        rx_field = f;
        iefc_dev_model_i.send(raw, w);
        repeat (6) @(posedge clk);
        #1 check(n_dec == 1, "result count");
        check(dec_field === f && dec_raw === raw, "raw bits");
        check(dec_value === val && dec_invalid === bad, "meaning");
    endtask

    task automatic t_reset();
        check(enc_ready === 1'b1 && enc_err === 1'b0, "reset encode side");
        check(tx_strobe === 1'b0 && dec_valid === 1'b0, "reset pins");
        $display("test reset done");
    endtask

    task automatic t_enc_key();
        logic bad;
        for (int k = 0; k < 16; k++) begin
            bad = !(k == 1 || k == 2 || k == 3 || k == 15);
            enc(iefc_pkg::F_KEY, 32'(k), 4, bad, 16'(k));
        end
        $display("test encode key mask done");
    endtask

    task automatic t_enc_fields();
        enc(iefc_pkg::F_LOC, 32'h0000_3FFF, 14, 0, 16'h3FFF);
        enc(iefc_pkg::F_LOC, 32'h0000_4000, 14, 1, 16'h0000);
        enc(iefc_pkg::F_LEN, 32'h0000_07FF, 11, 0, 16'h07FF);
        enc(iefc_pkg::F_LEN, 32'h0000_0800, 11, 1, 16'h0000);
        enc(iefc_pkg::F_MAXD, 32'h0000_0000, 8, 0, 16'h0000);
        enc(iefc_pkg::F_MAXD, 32'h0000_00FF, 8, 0, 16'h00FF);
        enc(iefc_pkg::F_CC, 32'h0000_03FF, 10, 0, 16'h03FF);
        enc(iefc_pkg::F_CC, 32'h0000_0400, 10, 1, 16'h0000);
        enc(iefc_pkg::F_IDX, 32'h0000_FFFF, 16, 0, 16'hFFFF);
        enc(iefc_pkg::F_IDX, 32'h0001_0000, 16, 1, 16'h0000);
        enc(iefc_pkg::F_REF, 32'h0000_00A5, 8, 0, 16'h00A5);
        enc(iefc_pkg::F_REF, 32'h0000_0100, 8, 1, 16'h0000);
        enc(iefc_pkg::F_CHR, 32'h0000_0041, 8, 0, 16'h0041);
        enc(4'hB, 32'h0000_0000, 4, 1, 16'h0000);
        $display("test encode plain fields done");
    endtask

    task automatic t_enc_mtu();
        logic [31:0] oct [5];
        oct = '{32'h0000_0128, 32'h0000_0240, 32'h0000_03EE,
                32'h0000_05DC, 32'h0000_07D2};
        for (int c = 1; c < 6; c++) begin
            enc(iefc_pkg::F_MTU, oct[c - 1], 3, 0, 16'(c));
        end
        enc(iefc_pkg::F_MTU, 32'h0000_0000, 3, 1, 16'h0000);
        enc(iefc_pkg::F_MTU, 32'h0000_05DD, 3, 1, 16'h0000);
        $display("test encode transmission unit done");
    endtask

    task automatic t_enc_thr();
        enc(iefc_pkg::F_THR, 32'h0000_0000, 5, 0, 16'h0000);
        for (int c = 1; c < 19; c++) begin
            enc(iefc_pkg::F_THR, thr_exp(c), 5, 0, 16'(c));
        end
        enc(iefc_pkg::F_THR, 32'hFFFF_FFFF, 5, 0, 16'h001F);
        enc(iefc_pkg::F_THR, 32'h0000_0096, 5, 1, 16'h0000);
        enc(iefc_pkg::F_THR, 32'h05F5_E100, 5, 1, 16'h0000);
        ctx_timer_run = 1'b0;
        enc(iefc_pkg::F_ACT, 32'h0000_0009, 4, 1, 16'h0000);
        ctx_timer_run = 1'b1;
        enc(iefc_pkg::F_ACT, 32'h0000_0009, 4, 0, 16'h0009);
        $display("test encode throughput done");
    endtask

    task automatic t_dec_codes();
        logic [25:0] v;
        logic        bad;
        for (int k = 0; k < 16; k++) begin
            bad = !(k == 1 || k == 2 || k == 3 || k == 15);
            v = bad ? 26'h000_0000 : 26'(k);
            dec(iefc_pkg::F_KEY, 16'(k), 4, v, bad);
        end
        dec(iefc_pkg::F_MTU, 16'h0003, 3, 26'h000_03EE, 0);
        dec(iefc_pkg::F_MTU, 16'h0004, 3, 26'h000_05DC, 0);
        dec(iefc_pkg::F_MTU, 16'h0005, 3, 26'h000_07D2, 0);
        dec(iefc_pkg::F_MTU, 16'h0006, 3, 26'h000_0000, 1);
        dec(iefc_pkg::F_MTU, 16'h0000, 3, 26'h000_0000, 1);
        for (int c = 0; c < 32; c++) begin
            bad = c > 18 && c < 31;
            v = (c == 31) ? 26'h3FF_FFFF : (c == 0 || bad) ? 26'h000_0000
                : 26'(thr_exp(c));
            dec(iefc_pkg::F_THR, 16'(c), 5, v, bad);
        end
        $display("test decode codes done");
    endtask

    task automatic t_dec_fields();
        dec(iefc_pkg::F_LOC, 16'h2AAA, 14, 26'h000_2AAA, 0);
        dec(iefc_pkg::F_LEN, 16'h07FF, 11, 26'h000_07FF, 0);
        dec(iefc_pkg::F_MAXD, 16'h0000, 8, 26'h000_0000, 0);
        dec(iefc_pkg::F_CC, 16'h0155, 10, 26'h000_0155, 0);
        dec(iefc_pkg::F_IDX, 16'hFFFF, 16, 26'h000_FFFF, 0);
        dec(iefc_pkg::F_REF, 16'h0080, 8, 26'h000_0080, 0);
        dec(iefc_pkg::F_CHR, 16'h0041, 8, 26'h000_0041, 0);
        dec(iefc_pkg::F_CHR, 16'h00C1, 8, 26'h000_0000, 1);
        dec(iefc_pkg::F_ACT, 16'h0006, 4, 26'h000_0006, 0);
        $display("test decode plain fields done");
    endtask

    initial begin
        rst_n = 1'b0;
        enc_valid = 1'b0;
        enc_field = 4'h0;
        enc_value = 32'h0000_0000;
        ctx_timer_run = 1'b0;
        rx_field = 4'h0;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        n_dec = 0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_enc_key();
        t_enc_fields();
        t_enc_mtu();
        t_enc_thr();
        t_dec_codes();
        t_dec_fields();
        wrap_up();
    end
endmodule
